// File: hw/fbo_pkg.sv
// Package with constants, types and timing for the flash bus host controller
// Notes on behaviour
// - To read, drive chip select and output enable low, write strobe high.
// - To write a command, drive write strobe and chip select low, output enable high.
// - During program or erase, reads return status bits; host may poll them.
// - After standby the host waits full chip-select access time before data valid.
// - After reset release the host waits the release-to-read interval.
// - Host should reissue a program or erase interrupted by a hardware reset.
package fbo_pkg;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 10;
    // Timing figures in ns; plain defaults
    localparam int MIN_CLEAR_PULSE_NS   = 500;
    localparam int CLEAR_RELEASE_NS     = 50;
    localparam int CE_ACCESS_NS         = 90;
    localparam int WRITE_PULSE_NS       = 45;
    localparam int RECOVERY_NS          = 20;
    localparam int MIN_CLEAR_PULSE_CYC  = (MIN_CLEAR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_RELEASE_CYC    = (CLEAR_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CE_ACCESS_CYC        = (CE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC      = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_CYC         = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam int REISSUE_DEPTH = 4;
    typedef enum logic [2:0] {
        FBO_IDLE    = 3'b000,
        FBO_READ    = 3'b001,
        FBO_WRITE   = 3'b010,
        FBO_RECOVER = 3'b011,
        FBO_CLEAR   = 3'b100,
        FBO_RELEASE = 3'b101
    } fbo_state_e;
endpackage

// File: hw/fbo_if.sv
// Interface between the controller and its command history memory
`timescale 1ns/1ps
interface fbo_hist_if;
    logic                                     wr_en;
    logic [1:0]                               wr_idx;
    logic [fbo_pkg::ADDR_W+fbo_pkg::DATA_W-1:0] wr_data;
    logic [1:0]                               rd_idx;
    logic [fbo_pkg::ADDR_W+fbo_pkg::DATA_W-1:0] rd_data;
    modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport mem  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// File: hw/fbo_hist_mem.sv
// Small memory holding the last write cycles of a command sequence
`timescale 1ns/1ps
module fbo_hist_mem (
    input wire logic sys_clk,
    fbo_hist_if.mem  hist
);
    logic [fbo_pkg::ADDR_W+fbo_pkg::DATA_W-1:0] mem_q [fbo_pkg::REISSUE_DEPTH];
    always_ff @(posedge sys_clk) begin
        if (hist.wr_en) begin
            mem_q[hist.wr_idx] <= hist.wr_data;
        end
    end
    always_ff @(posedge sys_clk) begin
        hist.rd_data <= mem_q[hist.rd_idx];
    end
endmodule

// File: hw/fbo_host.sv
// Host controller that drives the flash bus pins
`timescale 1ns/1ps
module fbo_host (
    input  wire logic                        sys_clk,
    input  wire logic                        nrst,
    input  wire logic                        req_valid,
    input  wire logic                        req_write,
    input  wire logic                        req_last,
    input  wire logic [fbo_pkg::ADDR_W-1:0]  req_addr,
    input  wire logic [fbo_pkg::DATA_W-1:0]  req_wdata,
    input  wire logic                        clear_req,
    input  wire logic                        reissue_req,
    output logic                             req_ready,
    output logic                             rsp_valid,
    output logic [fbo_pkg::DATA_W-1:0]       rsp_rdata,
    output logic                             was_busy_at_clear,
    output logic                             flash_busy,
    output logic [fbo_pkg::ADDR_W-1:0]       address_lines,
    output logic [fbo_pkg::DATA_W-1:0]       data_lines_o,
    output logic                             data_lines_oe,
    input  wire logic [fbo_pkg::DATA_W-1:0]  data_lines_i,
    output logic                             chip_sel_n,
    output logic                             out_en_n,
    output logic                             write_en_n,
    output logic                             clear_n,
    input  wire logic                        operation_pending_n
);
    // --------------------------------------------------------------
    // State and counters
    // --------------------------------------------------------------
    fbo_pkg::fbo_state_e       state_q;
    logic [fbo_pkg::CNT_W-1:0] cnt_q;
    logic [1:0]                hist_cnt_q;
    logic [1:0]                replay_idx_q;
    logic [1:0]                replay_left_q;
    logic                      replay_q;
    logic                      replay_wait_q;
    logic                      seq_open_q;
    fbo_hist_if                hist ();

    fbo_hist_mem u_hist (
        .sys_clk (sys_clk),
        .hist    (hist)
    );

    wire logic       host_go   = req_valid && req_ready && !replay_q;
    wire logic       replay_go = replay_q && !replay_wait_q && state_q == fbo_pkg::FBO_IDLE;

    assign hist.wr_en   = host_go && req_write;
    assign hist.wr_idx  = seq_open_q ? hist_cnt_q : 2'h0;
    assign hist.wr_data = {req_addr, req_wdata};
    assign hist.rd_idx  = replay_idx_q;

    // --------------------------------------------------------------
    // Bus state machine
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= fbo_pkg::FBO_IDLE;
            cnt_q   <= 8'h00;
        end else begin
            case (state_q)
                fbo_pkg::FBO_IDLE: begin
                    if (clear_req) begin
                        state_q <= fbo_pkg::FBO_CLEAR;
                        cnt_q   <= 8'(fbo_pkg::MIN_CLEAR_PULSE_CYC - 1);
                    end else if (replay_go || (host_go && req_write)) begin
                        state_q <= fbo_pkg::FBO_WRITE;
                        cnt_q   <= 8'(fbo_pkg::WRITE_PULSE_CYC - 1);
                    end else if (host_go) begin
                        state_q <= fbo_pkg::FBO_READ;
                        cnt_q   <= 8'(fbo_pkg::CE_ACCESS_CYC - 1);
                    end
                end
                fbo_pkg::FBO_READ, fbo_pkg::FBO_WRITE: begin
                    if (cnt_q == 8'h00) begin
                        state_q <= fbo_pkg::FBO_RECOVER;
                        cnt_q   <= 8'(fbo_pkg::RECOVERY_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                fbo_pkg::FBO_RECOVER: begin
                    if (cnt_q == 8'h00) begin
                        state_q <= fbo_pkg::FBO_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                fbo_pkg::FBO_CLEAR: begin
                    if (cnt_q == 8'h00) begin
                        state_q <= fbo_pkg::FBO_RELEASE;
                        cnt_q   <= 8'(fbo_pkg::CLEAR_RELEASE_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                fbo_pkg::FBO_RELEASE: begin
                    if (cnt_q == 8'h00 && operation_pending_n) begin
                        state_q <= fbo_pkg::FBO_IDLE;
                    end else if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= fbo_pkg::FBO_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Pin drive
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            chip_sel_n    <= 1'b1;
            out_en_n      <= 1'b1;
            write_en_n    <= 1'b1;
            clear_n       <= 1'b1;
            data_lines_oe <= 1'b0;
            data_lines_o  <= 8'h00;
            address_lines <= 21'h000000;
        end else begin
            if (state_q == fbo_pkg::FBO_IDLE && clear_req) begin
                clear_n       <= 1'b0;
                chip_sel_n    <= 1'b1;
                out_en_n      <= 1'b1;
                write_en_n    <= 1'b1;
                data_lines_oe <= 1'b0;
            end else if (state_q == fbo_pkg::FBO_IDLE && replay_go) begin
                chip_sel_n    <= 1'b0;
                out_en_n      <= 1'b1;
                write_en_n    <= 1'b0;
                data_lines_oe <= 1'b1;
                address_lines <= hist.rd_data[fbo_pkg::ADDR_W+fbo_pkg::DATA_W-1:fbo_pkg::DATA_W];
                data_lines_o  <= hist.rd_data[fbo_pkg::DATA_W-1:0];
            end else if (state_q == fbo_pkg::FBO_IDLE && host_go) begin
                chip_sel_n    <= 1'b0;
                address_lines <= req_addr;
                if (req_write) begin
                    out_en_n      <= 1'b1;
                    write_en_n    <= 1'b0;
                    data_lines_oe <= 1'b1;
                    data_lines_o  <= req_wdata;
                end else begin
                    out_en_n      <= 1'b0;
                    write_en_n    <= 1'b1;
                    data_lines_oe <= 1'b0;
                end
            end else if ((state_q == fbo_pkg::FBO_READ || state_q == fbo_pkg::FBO_WRITE)
                         && cnt_q == 8'h00) begin
                chip_sel_n    <= 1'b1;
                out_en_n      <= 1'b1;
                write_en_n    <= 1'b1;
            end else if (state_q == fbo_pkg::FBO_RECOVER) begin
                data_lines_oe <= 1'b0;
            end else if (state_q == fbo_pkg::FBO_CLEAR && cnt_q == 8'h00) begin
                clear_n <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // Read capture and status
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
        end else begin
            rsp_valid <= state_q == fbo_pkg::FBO_READ && cnt_q == 8'h00;
            if (state_q == fbo_pkg::FBO_READ && cnt_q == 8'h00) begin
                rsp_rdata <= data_lines_i;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            req_ready         <= 1'b0;
            flash_busy        <= 1'b0;
            was_busy_at_clear <= 1'b0;
        end else begin
            req_ready  <= state_q == fbo_pkg::FBO_IDLE && !host_go && !replay_go
                          && !clear_req && !replay_q;
            flash_busy <= !operation_pending_n;
            if (state_q == fbo_pkg::FBO_IDLE && clear_req) begin
                was_busy_at_clear <= !operation_pending_n;
            end
        end
    end

    // --------------------------------------------------------------
    // Sequence history and reissue after clear
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            seq_open_q <= 1'b0;
            hist_cnt_q <= 2'h0;
        end else if (host_go && req_write) begin
            seq_open_q <= !req_last;
            hist_cnt_q <= (seq_open_q ? hist_cnt_q : 2'h0) + 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            replay_q      <= 1'b0;
            replay_wait_q <= 1'b0;
            replay_idx_q  <= 2'h0;
            replay_left_q <= 2'h0;
        end else if (!replay_q) begin
            replay_wait_q <= 1'b1;
            replay_idx_q  <= 2'h0;
            if (reissue_req && state_q == fbo_pkg::FBO_IDLE && !clear_req
                && !req_valid && !seq_open_q && hist_cnt_q != 2'h0) begin
                replay_q      <= 1'b1;
                replay_left_q <= hist_cnt_q - 2'h1;
            end
        end else if (replay_go) begin
            replay_wait_q <= 1'b1;
            replay_idx_q  <= replay_idx_q + 2'h1;
            replay_left_q <= replay_left_q - 2'h1;
            if (replay_left_q == 2'h0) begin
                replay_q <= 1'b0;
            end
        end else if (state_q == fbo_pkg::FBO_IDLE) begin
            replay_wait_q <= 1'b0;
        end
    end
endmodule

// File: dv/fbo_host_chk.sv
// Assertion checker on the flash host controller pins
`timescale 1ns/1ps
module fbo_host_chk (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic data_lines_oe,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic clear_n
);
    // ----------------------------------------
    // Pin relations
    // ----------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [7:0] low_q;
    always_ff @(posedge sys_clk) begin
        if (!nrst || clear_n) begin
            low_q <= 8'h00;
        end else begin
            low_q <= low_q + 8'h01;
        end
    end
    sequence rd_take; req_valid && req_ready && !req_write; endsequence
    sequence wr_take; req_valid && req_ready && req_write; endsequence
    sequence rd_pins; !chip_sel_n && !out_en_n; endsequence
    chk_read_levels: assert property (rd_pins |-> write_en_n && !data_lines_oe)
        else $error("read strobes wrong");
    chk_write_levels: assert property (!write_en_n |-> !chip_sel_n && out_en_n && data_lines_oe)
        else $error("write strobes wrong");
    chk_clear_quiet: assert property (!clear_n |-> chip_sel_n && out_en_n && write_en_n)
        else $error("access during clear");
    chk_clear_width: assert property ($rose(clear_n) |-> low_q >= fbo_pkg::MIN_CLEAR_PULSE_CYC)
        else $error("clear pulse short");
    chk_release_wait: assert property ($rose(clear_n) |-> out_en_n [*5])
        else $error("read too soon after clear");
    chk_read_timing: assert property (rd_take |=> rd_pins [*8] ##1 rd_pins ##1 rsp_valid)
        else $error("read access timing wrong");
    chk_write_pulse: assert property (wr_take |=> (!write_en_n) [*4] ##[1:2] write_en_n)
        else $error("write pulse wrong");
    chk_clear_refuse: assert property (!clear_n |-> !req_ready)
        else $error("ready during clear");
endmodule

// File: dv/fbo_flash_model.sv
// Behavioural model of the byte-wide flash device
`timescale 1ns/1ps
module fbo_flash_model #(
    parameter logic [7:0] ID_BYTE  = 8'h5E, // Arbitrary identification value
    parameter int         BUSY_CYC = 30,
    parameter int         RST_CYC  = 4
) (
    input  wire logic        sys_clk,
    input  wire logic [20:0] address_lines,
    input  wire logic [7:0]  din,
    input  wire logic        chip_sel_n,
    input  wire logic        out_en_n,
    input  wire logic        write_en_n,
    input  wire logic        clear_n,
    output logic [7:0]       dout,
    output logic             dout_en,
    output logic             operation_pending_n
);
    // ----------------------------------------
    // Array, command latches and busy timer
    // ----------------------------------------
    logic [7:0]  mem [256];
    logic [1:0]  mode_q = 2'h0;
    int          busy_q = 0;
    logic        ab_q = 1'b0;
    logic        wact_q = 1'b0;
    logic [20:0] wa_q = 21'h000000;
    logic [7:0]  wd_q = 8'h00;
    logic [20:0] pa_q;
    logic [7:0]  pd_q;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    assign operation_pending_n = (busy_q == 0);
    assign dout_en = !chip_sel_n && !out_en_n && write_en_n && clear_n;
    assign dout = (busy_q != 0) ? {~pd_q[7], 7'h00} : (mode_q == 2'h1) ? ID_BYTE : mem[address_lines[7:0]];
    // Latches take command, address and data while strobed; no mapped location
    // Command acts when the strobe ends; work runs on while deselected
    always @(posedge sys_clk) begin
        wact_q <= !chip_sel_n && !write_en_n && clear_n;
        if (!chip_sel_n && !write_en_n && clear_n) begin
            wa_q <= address_lines;
            wd_q <= din;
        end else if (wact_q && clear_n && busy_q == 0) begin
            if (mode_q == 2'h2) begin
                pa_q <= wa_q;
                pd_q <= wd_q;
                busy_q <= BUSY_CYC;
                mode_q <= 2'h0;
            end else if (wd_q == 8'hA0) mode_q <= 2'h2;
            else if (wd_q == 8'h90) mode_q <= 2'h1;
            else if (wd_q == 8'hF0) mode_q <= 2'h0;
        end
        if (busy_q == 1 && !ab_q && clear_n) mem[pa_q[7:0]] <= pd_q;
        if (busy_q != 0) busy_q <= busy_q - 1;
        else ab_q <= 1'b0;
        if (!clear_n) begin
            mode_q <= 2'h0;
            if (busy_q != 0) ab_q <= 1'b1;
            if (busy_q > RST_CYC) busy_q <= RST_CYC;
        end
    end
endmodule

// File: dv/tb.sv
// Self-checking testbench for the flash host controller
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // Stimulus, flash model and checks
    // ----------------------------------------
    typedef struct packed {
        logic wr; logic lst; logic wi; logic [20:0] a; logic [7:0] d; logic [7:0] e;
    } fbo_row_s;
    localparam logic [7:0] ID_V = 8'h5E; // Arbitrary identification value
    logic sys_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_last = 1'b0;
    logic clear_req = 1'b0, reissue_req = 1'b0, req_ready, rsp_valid, was_busy_at_clear;
    logic flash_busy, data_lines_oe, chip_sel_n, out_en_n, write_en_n, clear_n, pend_n, fl_en;
    logic [20:0] req_addr = 21'h000000, address_lines;
    logic [7:0]  req_wdata = 8'h00, rsp_rdata, data_lines_o, fl_d, bus, last_q = 8'h00;
    int          failures = 0, n_compared = 0;
    fbo_row_s    rows [10];
    always #5 sys_clk = ~sys_clk;
    assign bus = fl_en ? fl_d : (data_lines_oe ? data_lines_o : ~last_q);
    always @(posedge sys_clk) last_q <= bus;
    fbo_host dut (.sys_clk, .nrst, .req_valid, .req_write, .req_last, .req_addr, .req_wdata,
        .clear_req, .reissue_req, .req_ready, .rsp_valid, .rsp_rdata, .was_busy_at_clear,
        .flash_busy, .address_lines, .data_lines_o, .data_lines_oe, .data_lines_i(bus),
        .chip_sel_n, .out_en_n, .write_en_n, .clear_n, .operation_pending_n(pend_n));
    fbo_flash_model #(.ID_BYTE(ID_V)) u_flash (.sys_clk, .address_lines, .din(bus), .chip_sel_n,
        .out_en_n, .write_en_n, .clear_n, .dout(fl_d), .dout_en(fl_en), .operation_pending_n(pend_n));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bad(input string m);
        failures++;
        $display("FAIL %0t: %s", $time, m);
        conclude();
    endtask
    task automatic wait_idle();
        int n = 0;
        do begin @(posedge sys_clk); n++; end while ((flash_busy !== 1'b0 || req_ready !== 1'b1) && n < 500);
        if (n >= 500) bad("idle wait timed out");
    endtask
    task automatic req(input fbo_row_s r);
        int n = 0;
        req_write <= r.wr;
        req_last <= r.lst;
        req_addr <= r.a;
        req_wdata <= r.d;
        req_valid <= 1'b1;
        do begin @(posedge sys_clk); n++; end while (req_ready !== 1'b1 && n < 100);
        req_valid <= 1'b0;
        if (n >= 100) bad("request not taken");
        if (!r.wr) begin
            n = 0;
            do begin @(posedge sys_clk); #1; n++; end while (rsp_valid !== 1'b1 && n < 30);
            if (n >= 30) bad("no read answer");
            chk(rsp_rdata, r.e);
        end
        @(posedge sys_clk);
    endtask
    task automatic clear(input logic busy_exp);
        int n = 0;
        clear_req <= 1'b1;
        do begin @(posedge sys_clk); n++; end while (clear_n !== 1'b0 && n < 50);
        clear_req <= 1'b0;
        if (n >= 50) bad("clear not started");
        wait_idle();
        chk({7'h00, was_busy_at_clear}, {7'h00, busy_exp});
    endtask
    initial begin
        rows = '{'{0, 0, 0, 21'h10, 8'h00, 8'hB5}, '{0, 0, 0, 21'h11, 8'h00, 8'hB4},
                 '{1, 1, 0, 21'h00, 8'h90, 8'h00}, '{0, 0, 0, 21'h00, 8'h00, ID_V},
                 '{1, 1, 0, 21'h00, 8'hF0, 8'h00}, '{0, 0, 0, 21'h11, 8'h00, 8'hB4},
                 '{1, 0, 0, 21'h555, 8'hA0, 8'h00}, '{1, 1, 0, 21'h20, 8'h3C, 8'h00},
                 '{0, 0, 0, 21'h20, 8'h00, 8'h80}, '{0, 0, 1, 21'h20, 8'h00, 8'h3C}};
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        wait_idle();
        foreach (rows[i]) begin
            if (rows[i].wi) wait_idle();
            req(rows[i]);
        end
        wait_idle();
        req('{1, 0, 0, 21'h555, 8'hA0, 8'h00});
        req('{1, 1, 0, 21'h30, 8'h66, 8'h00});
        clear(1'b1);
        req('{0, 0, 0, 21'h30, 8'h00, 8'h95});
        wait_idle();
        reissue_req <= 1'b1;
        @(posedge sys_clk);
        reissue_req <= 1'b0;
        repeat (20) @(posedge sys_clk);
        wait_idle();
        req('{0, 0, 0, 21'h30, 8'h00, 8'h66});
        req('{1, 1, 0, 21'h00, 8'h90, 8'h00});
        clear(1'b0);
        req('{0, 0, 0, 21'h00, 8'h00, 8'hA5});
        conclude();
    end
endmodule
bind fbo_host fbo_host_chk u_chk (.sys_clk, .nrst, .req_valid, .req_write, .req_ready, .rsp_valid,
    .data_lines_oe, .chip_sel_n, .out_en_n, .write_en_n, .clear_n);
